// ### rtl/adc_link_pkg.sv
// Shared constants and types for the two-wire converter slave
package adc_link_pkg;

	// ----------------------------------------------------------------
	// Clock and link timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ = 50_000_000;
	localparam int SCL_MAX_HZ = 3_400_000;
	localparam int SCL_MAX_KHZ = SCL_MAX_HZ / 1000;

	// ----------------------------------------------------------------
	// Address byte layout
	// ----------------------------------------------------------------
	// Device type code: value is arbitrary
	localparam logic [4:0] DEV_TYPE = 5'h15;
	localparam int ADDR_TYPE_MSB = 7;
	localparam int ADDR_TYPE_LSB = 3;
	localparam int ADDR_SEL1_POS = 2;
	localparam int ADDR_SEL0_POS = 1;
	localparam int ADDR_RW_POS = 0;

	// ----------------------------------------------------------------
	// Command byte layout
	// ----------------------------------------------------------------
	localparam int CMD_MODE_POS = 7;
	localparam int CMD_CH2_POS = 6;
	localparam int CMD_CH1_POS = 5;
	localparam int CMD_CH0_POS = 4;
	localparam int CMD_PWR1_POS = 3;
	localparam int CMD_PWR0_POS = 2;
	// Bits already shifted in when the channel bits are complete
	localparam logic [3:0] CMD_CHAN_BITS = 4'h4;
	localparam logic [3:0] BYTE_BITS = 4'h8;

	// ----------------------------------------------------------------
	// Result layout and reset values
	// ----------------------------------------------------------------
	localparam int RES_W = 10;
	localparam int RES_HI_W = 4;
	localparam int RES_LO_W = 6;
	localparam logic [3:0] RES_HI_PAD = 4'h0;
	localparam logic [1:0] RES_LO_PAD = 2'h0;
	localparam int FIFO_DEPTH = 32;
	localparam logic [1:0] PD_RESET = 2'h0;
	localparam logic [2:0] CHAN_RESET = 3'h0;
	// Edges after reset release before the strap synchroniser is valid
	localparam logic [1:0] STRAP_WAIT = 2'h2;

	// ----------------------------------------------------------------
	// Protocol state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_ADDR = 3'h1,
		ST_ACK_ADDR = 3'h2,
		ST_RX = 3'h3,
		ST_ACK_RX = 3'h4,
		ST_TX = 3'h5,
		ST_ACK_TX = 3'h6
	} link_state_t;

endpackage

// ### rtl/line_events_if.sv
// Decoded line events passed from the pin sampler to the protocol logic
interface line_events_if;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic sda_lvl;

	modport src (
		output scl_rise,
		output scl_fall,
		output start_cond,
		output stop_cond,
		output sda_lvl
	);
	modport dst (
		input scl_rise,
		input scl_fall,
		input start_cond,
		input stop_cond,
		input sda_lvl
	);
endinterface

// ### rtl/result_fifo.sv
// Result FIFO with registered read data and honest full and empty
module result_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 32
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic wr_fire;
	logic rd_fire;

	// Full is exact, so the filling side sees back-pressure
	assign in_ready_out = (count_r != FULL_CNT);
	assign wr_fire = in_valid_in && in_ready_out;
	assign rd_fire = out_valid_out && out_ready_in;

	// Storage write
	always_ff @(posedge clk_in) begin
		if (wr_fire) begin
			mem_r[wr_ptr_r] <= in_data_in;
		end
	end

	// Registered read; data settles one cycle after a pointer move
	always_ff @(posedge clk_in) begin
		out_data_out <= mem_r[rd_ptr_r];
	end

	// Pointers and fill count
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end else begin
			if (wr_fire) begin
				wr_ptr_r <= wr_ptr_r + 1'b1;
			end
			if (rd_fire) begin
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
			count_r <= count_r + (AW+1)'(wr_fire) - (AW+1)'(rd_fire);
		end
	end

	// Valid drops for a cycle after each pop so stale data never shows
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			out_valid_out <= 1'b0;
		end else begin
			out_valid_out <= (count_r != '0) && !rd_fire;
		end
	end
endmodule

// ### rtl/line_sampler.sv
// Synchronises the serial pins and decodes edges and bus conditions
module line_sampler (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic scl_in,
	input wire logic sda_in,
	line_events_if.src ev
);
	logic [2:0] scl_sync_r;
	logic [2:0] sda_sync_r;

	// Two flops per pin, a third only for edge history
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			scl_sync_r <= 3'h7;
			sda_sync_r <= 3'h7;
		end else begin
			scl_sync_r <= {scl_sync_r[1:0], scl_in};
			sda_sync_r <= {sda_sync_r[1:0], sda_in};
		end
	end

	// Edge and condition decode, registered
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ev.scl_rise <= 1'b0;
			ev.scl_fall <= 1'b0;
			ev.start_cond <= 1'b0;
			ev.stop_cond <= 1'b0;
			ev.sda_lvl <= 1'b1;
		end else begin
			ev.scl_rise <= scl_sync_r[1] && !scl_sync_r[2];
			ev.scl_fall <= !scl_sync_r[1] && scl_sync_r[2];
			// RQ3: data move with clock high is a condition
			// RQ4: falling data is start, rising is stop
			ev.start_cond <= scl_sync_r[1] && scl_sync_r[2] && sda_sync_r[2] && !sda_sync_r[1];
			ev.stop_cond <= scl_sync_r[1] && scl_sync_r[2] && !sda_sync_r[2] && sda_sync_r[1];
			ev.sda_lvl <= sda_sync_r[1];
		end
	end
endmodule

// ### rtl/adc_link_slave.sv
// Two-wire slave front end of a multi-channel converter
// Notes on behaviour
// RQ1: Slave only, master clock up to 3.4 MHz
// RQ2: Transfers start only from an idle bus
// RQ3: Data moves with clock high are conditions
// RQ4: Falling data is start, rising is stop
// RQ5: Eight-bit bytes each followed by acknowledge
// RQ6: Acknowledger holds data low through clock high
// RQ7: Master nack ends read; device releases data
// RQ8: Write: acknowledge address and every data byte
// RQ9: Read: device sends bytes after address ack
// RQ10: Repeated start restarts with fresh address byte
// RQ11: First byte after any start is address
// RQ12: Top five address bits match type code
// RQ13: Next two bits match strapped select pins
// RQ14: Lowest address bit: one read, zero write
// RQ15: Ack only on full match, then pick direction
// RQ16: Command byte sets mode, channel, power
// RQ17: Power bits decode reference and converter enables
// RQ18: Core and clock off when idle, not converting
// RQ19: Result is ten-bit straight binary code
// RQ20: Channel mapping for single-ended and differential
// RQ21: Conversion starts once channel bits arrive
// RQ22: Result sent as two padded bytes
// RQ23: Reference turns on at next stop or restart
// RQ24: Release data line and ignore until start
// RQ25: Shift out MSB first, change with clock low
module adc_link_slave (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic addr_select_pin1_in,
	input wire logic addr_select_pin0_in,
	input wire logic conv_done_in,
	input wire logic [9:0] result_in,
	output logic sda_o_out,
	output logic sda_oe_out,
	output logic conv_start_out,
	output logic [2:0] mux_pos_out,
	output logic [2:0] mux_neg_out,
	output logic neg_common_out,
	output logic input_mode_select_out,
	output logic [1:0] power_mode_out,
	output logic ref_on_out,
	output logic adc_power_out,
	output logic core_clk_en_out
);
	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	line_events_if ev ();
	adc_link_pkg::link_state_t state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] rx_shreg_r;
	logic [7:0] tx_shreg_r;
	logic rw_r;
	logic mack_r;
	logic byte_sel_r;
	logic [adc_link_pkg::RES_W-1:0] cur_res_r;
	logic [1:0] pin_sync1_r;
	logic [1:0] pin_sync2_r;
	logic [1:0] sel_r;
	logic sel_taken_r;
	logic [1:0] cap_wait_r;
	logic converting_r;
	logic ref_pending_r;
	logic [7:0] addr_byte;
	logic addr_match;
	logic [7:0] cmd_byte;
	logic chan_done;
	logic [adc_link_pkg::RES_W-1:0] tx_res;
	logic [7:0] hi_byte;
	logic [7:0] lo_byte;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic [adc_link_pkg::RES_W-1:0] fifo_out_data;
	logic push_res;

	// ----------------------------------------------------------------
	// Pin sampling and result buffer
	// ----------------------------------------------------------------
	// RQ1: slave sampling only; 50 MHz sampling suits slower SCL best
	line_sampler u_sampler (
		.clk_in(mclk_in),
		.rstn_in(rstn_in),
		.scl_in(scl_in),
		.sda_in(sda_in),
		.ev(ev)
	);

	result_fifo #(
		.WIDTH(adc_link_pkg::RES_W),
		.DEPTH(adc_link_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_in(mclk_in),
		.rstn_in(rstn_in),
		.in_valid_in(push_res),
		.in_ready_out(fifo_in_ready),
		.in_data_in(result_in),
		.out_valid_out(fifo_out_valid),
		.out_ready_in(fifo_pop),
		.out_data_out(fifo_out_data)
	);

	// ----------------------------------------------------------------
	// Select strap capture
	// ----------------------------------------------------------------
	// Straps pass two flops, then are caught once after reset release
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pin_sync1_r <= 2'h0;
			pin_sync2_r <= 2'h0;
		end else begin
			pin_sync1_r <= {addr_select_pin1_in, addr_select_pin0_in};
			pin_sync2_r <= pin_sync1_r;
		end
	end

	// RQ13: select bits fixed at startup
	// Waits until the synchroniser holds the straps, not its reset value
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sel_r <= 2'h0;
			sel_taken_r <= 1'b0;
			cap_wait_r <= 2'h0;
		end else if (!sel_taken_r) begin
			if (cap_wait_r == adc_link_pkg::STRAP_WAIT) begin
				sel_r <= pin_sync2_r;
				sel_taken_r <= 1'b1;
			end else begin
				cap_wait_r <= cap_wait_r + 2'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Byte decode
	// ----------------------------------------------------------------
	// Completed byte including the bit sampled now
	assign addr_byte = {rx_shreg_r[6:0], ev.sda_lvl};
	assign cmd_byte = rx_shreg_r;
	// RQ12: type code compare
	// RQ13: select bit compare
	assign addr_match = (rx_shreg_r[adc_link_pkg::ADDR_TYPE_MSB:adc_link_pkg::ADDR_TYPE_LSB]
		== adc_link_pkg::DEV_TYPE)
		&& (rx_shreg_r[adc_link_pkg::ADDR_SEL1_POS] == sel_r[1])
		&& (rx_shreg_r[adc_link_pkg::ADDR_SEL0_POS] == sel_r[0]);
	// RQ21: channel bits complete once four bits are in
	assign chan_done = (state_r == adc_link_pkg::ST_RX) && ev.scl_rise
		&& (bit_cnt_r == adc_link_pkg::CMD_CHAN_BITS - 4'h1);

	// RQ19: straight binary code, buffered result or last one sent
	assign tx_res = fifo_out_valid ? fifo_out_data : cur_res_r;
	// RQ22: four zeros over top bits, low bits over two zeros
	assign hi_byte = {adc_link_pkg::RES_HI_PAD,
		tx_res[adc_link_pkg::RES_W-1 -: adc_link_pkg::RES_HI_W]};
	assign lo_byte = {cur_res_r[adc_link_pkg::RES_LO_W-1:0], adc_link_pkg::RES_LO_PAD};
	// A new read pops when a result waits; within a read only ahead of a high byte
	assign fifo_pop = fifo_out_valid && ev.scl_fall
		&& ((state_r == adc_link_pkg::ST_ACK_ADDR && rw_r)
		|| (state_r == adc_link_pkg::ST_ACK_TX && !mack_r && !byte_sel_r));

	// ----------------------------------------------------------------
	// Protocol sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_r <= adc_link_pkg::ST_IDLE;
			bit_cnt_r <= 4'h0;
			rx_shreg_r <= 8'h00;
			tx_shreg_r <= 8'hff;
			rw_r <= 1'b0;
			mack_r <= 1'b1;
			byte_sel_r <= 1'b0;
			cur_res_r <= '0;
			sda_oe_out <= 1'b0;
		end else if (ev.start_cond) begin
			// RQ10: repeated start reopens with address
			// RQ11: first byte after start is address
			state_r <= adc_link_pkg::ST_ADDR;
			bit_cnt_r <= 4'h0;
			sda_oe_out <= 1'b0;
		end else if (ev.stop_cond) begin
			// RQ2: bus idle after stop
			state_r <= adc_link_pkg::ST_IDLE;
			sda_oe_out <= 1'b0;
		end else if (ev.scl_rise) begin
			// RQ5: eight data bits per byte
			unique case (state_r)
				adc_link_pkg::ST_ADDR,
				adc_link_pkg::ST_RX: begin
					rx_shreg_r <= addr_byte;
					bit_cnt_r <= bit_cnt_r + 4'h1;
				end
				// RQ9: master answers each byte
				adc_link_pkg::ST_ACK_TX: begin
					mack_r <= ev.sda_lvl;
				end
				adc_link_pkg::ST_IDLE,
				adc_link_pkg::ST_ACK_ADDR,
				adc_link_pkg::ST_ACK_RX,
				adc_link_pkg::ST_TX: begin
				end
			endcase
		end else if (ev.scl_fall) begin
			unique case (state_r)
				// RQ24: ignore traffic until next start
				adc_link_pkg::ST_IDLE: begin
					sda_oe_out <= 1'b0;
				end
				adc_link_pkg::ST_ADDR: begin
					if (bit_cnt_r == adc_link_pkg::BYTE_BITS) begin
						// RQ15: ack only on full match
						if (addr_match) begin
							state_r <= adc_link_pkg::ST_ACK_ADDR;
							// RQ14: lowest bit picks direction
							rw_r <= rx_shreg_r[adc_link_pkg::ADDR_RW_POS];
							// RQ6: hold low through ack pulse
							sda_oe_out <= 1'b1;
						end else begin
							state_r <= adc_link_pkg::ST_IDLE;
						end
					end
				end
				adc_link_pkg::ST_ACK_ADDR: begin
					bit_cnt_r <= 4'h0;
					if (rw_r) begin
						// RQ9: transmit after address ack
						// RQ25: first bit out with clock low
						state_r <= adc_link_pkg::ST_TX;
						tx_shreg_r <= {hi_byte[6:0], 1'b1};
						sda_oe_out <= !hi_byte[7];
						cur_res_r <= tx_res;
						byte_sel_r <= 1'b1;
						bit_cnt_r <= 4'h1;
					end else begin
						// RQ15: receiver mode on write
						state_r <= adc_link_pkg::ST_RX;
						sda_oe_out <= 1'b0;
					end
				end
				adc_link_pkg::ST_RX: begin
					if (bit_cnt_r == adc_link_pkg::BYTE_BITS) begin
						// RQ8: ack every written byte
						state_r <= adc_link_pkg::ST_ACK_RX;
						sda_oe_out <= 1'b1;
					end
				end
				adc_link_pkg::ST_ACK_RX: begin
					// RQ24: release between own bits
					state_r <= adc_link_pkg::ST_RX;
					bit_cnt_r <= 4'h0;
					sda_oe_out <= 1'b0;
				end
				adc_link_pkg::ST_TX: begin
					if (bit_cnt_r == adc_link_pkg::BYTE_BITS) begin
						state_r <= adc_link_pkg::ST_ACK_TX;
						sda_oe_out <= 1'b0;
					end else begin
						// RQ25: MSB first, change with clock low
						sda_oe_out <= !tx_shreg_r[7];
						tx_shreg_r <= {tx_shreg_r[6:0], 1'b1};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end
				end
				adc_link_pkg::ST_ACK_TX: begin
					if (mack_r) begin
						// RQ7: nack ends read, line left released
						state_r <= adc_link_pkg::ST_IDLE;
						sda_oe_out <= 1'b0;
					end else begin
						state_r <= adc_link_pkg::ST_TX;
						bit_cnt_r <= 4'h1;
						byte_sel_r <= !byte_sel_r;
						if (byte_sel_r) begin
							tx_shreg_r <= {lo_byte[6:0], 1'b1};
							sda_oe_out <= !lo_byte[7];
						end else begin
							tx_shreg_r <= {hi_byte[6:0], 1'b1};
							sda_oe_out <= !hi_byte[7];
							cur_res_r <= tx_res;
						end
					end
				end
				default: begin
					state_r <= adc_link_pkg::ST_IDLE;
					sda_oe_out <= 1'b0;
				end
			endcase
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			sda_o_out <= 1'b0;
		end else begin
			sda_o_out <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Command byte and reference control
	// ----------------------------------------------------------------
	// RQ16: full command byte sets mode and power
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			input_mode_select_out <= 1'b0;
			power_mode_out <= adc_link_pkg::PD_RESET;
		end else if (ev.scl_fall && state_r == adc_link_pkg::ST_RX
			&& bit_cnt_r == adc_link_pkg::BYTE_BITS) begin
			input_mode_select_out <= cmd_byte[adc_link_pkg::CMD_MODE_POS];
			power_mode_out <= {cmd_byte[adc_link_pkg::CMD_PWR1_POS],
				cmd_byte[adc_link_pkg::CMD_PWR0_POS]};
		end
	end

	// RQ23: reference waits for stop or restart; clear turns off at once
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ref_on_out <= 1'b0;
			ref_pending_r <= 1'b0;
		end else if (ev.scl_fall && state_r == adc_link_pkg::ST_RX
			&& bit_cnt_r == adc_link_pkg::BYTE_BITS) begin
			// RQ17: power bit one enables the reference
			if (cmd_byte[adc_link_pkg::CMD_PWR1_POS]) begin
				ref_pending_r <= !ref_on_out;
			end else begin
				ref_on_out <= 1'b0;
				ref_pending_r <= 1'b0;
			end
		end else if ((ev.stop_cond || ev.start_cond) && ref_pending_r) begin
			ref_on_out <= 1'b1;
			ref_pending_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Conversion control
	// ----------------------------------------------------------------
	// RQ20: positive input is low channel bits then top bit
	// RQ21: start as soon as channel bits are in
	// A full buffer holds off new conversions, so results are never lost
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			conv_start_out <= 1'b0;
			converting_r <= 1'b0;
			mux_pos_out <= adc_link_pkg::CHAN_RESET;
			mux_neg_out <= adc_link_pkg::CHAN_RESET;
			neg_common_out <= 1'b0;
		end else begin
			conv_start_out <= 1'b0;
			if (chan_done && !converting_r && fifo_in_ready) begin
				conv_start_out <= 1'b1;
				converting_r <= 1'b1;
				mux_pos_out <= {rx_shreg_r[0], ev.sda_lvl, rx_shreg_r[1]};
				mux_neg_out <= {rx_shreg_r[0], ev.sda_lvl, !rx_shreg_r[1]};
				neg_common_out <= rx_shreg_r[2];
			end else if (conv_done_in) begin
				converting_r <= 1'b0;
			end
		end
	end
	assign push_res = conv_done_in && converting_r;

	// RQ18: core clock only while converting or out of idle (from any start)
	// RQ17: low power bit keeps the converter powered
	always_ff @(posedge mclk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			core_clk_en_out <= 1'b0;
			adc_power_out <= 1'b0;
		end else begin
			core_clk_en_out <= converting_r || (state_r != adc_link_pkg::ST_IDLE);
			adc_power_out <= converting_r || (state_r != adc_link_pkg::ST_IDLE)
				|| power_mode_out[0];
		end
	end
endmodule

// ### dv/two_wire_master.sv
// Bus master model: drives the serial clock, conditions and bytes
module two_wire_master (
	input wire logic mclk_in,
	input wire logic sda_in,
	output logic scl_out,
	output logic sda_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// --------------------------------------------------------------
	// Clock stands high between frames; pull-up gives released lines
	// --------------------------------------------------------------
	// idle bus
	initial begin
		scl_out = 1'b1;
		sda_out = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	// data set with clock low, read late in the high phase
	task automatic clk_bit(input logic v, output logic r);
		sda_out = v;
		tick(3);
		scl_out = 1'b1;
		tick(3);
		r = sda_in;
		scl_out = 1'b0;
		tick(2);
	endtask
	// start, or repeated start from a low clock
	task automatic start_c();
		if (!scl_out) begin
			sda_out = 1'b1;
			tick(3);
			scl_out = 1'b1;
			tick(5);
		end
		sda_out = 1'b0;
		tick(5);
		scl_out = 1'b0;
		tick(2);
	endtask
	task automatic stop_c();
		sda_out = 1'b0;
		tick(3);
		scl_out = 1'b1;
		tick(5);
		sda_out = 1'b1;
		tick(10);
	endtask
	// eight bits then the acknowledge pulse
	task automatic xfer(input logic [7:0] tx, input logic ak_in, output logic [7:0] rx,
		output logic ak_out);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(tx[i], b);
			rx[i] = b;
		end
		clk_bit(ak_in, ak_out);
	endtask
endmodule

// ### dv/adc_link_slave_asserts.sv
// Port-level checks for the converter slave
module adc_link_slave_asserts (
	input wire logic mclk_in,
	input wire logic rstn_in,
	input wire logic scl_in,
	input wire logic conv_done_in,
	input wire logic sda_o_out,
	input wire logic sda_oe_out,
	input wire logic conv_start_out,
	input wire logic [2:0] mux_pos_out,
	input wire logic [2:0] mux_neg_out,
	input wire logic input_mode_select_out,
	input wire logic [1:0] power_mode_out,
	input wire logic ref_on_out,
	input wire logic adc_power_out,
	input wire logic core_clk_en_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// --------------------------------------------------------------
	// Checks
	// --------------------------------------------------------------
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rstn_in);
	oe_low_clock_a: assert property ($changed(sda_oe_out) |-> !scl_in)
		else $error("data line moved with clock high");
	open_drain_a: assert property (sda_oe_out |-> !sda_o_out)
		else $error("data line driven high");
	oe_in_xfer_a: assert property (sda_oe_out |-> core_clk_en_out)
		else $error("data line pulled while idle");
	start_pulse_a: assert property (conv_start_out |=> !conv_start_out)
		else $error("start pulse longer than one cycle");
	core_clock_on_a: assert property (conv_start_out || conv_done_in |-> core_clk_en_out)
		else $error("core clock off while converting");
	mux_pair_a: assert property ($changed(mux_pos_out) |->
		mux_neg_out == {mux_pos_out[2:1], ~mux_pos_out[0]})
		else $error("negative channel not paired");
	ref_at_cond_a: assert property ($rose(ref_on_out) |-> scl_in && $past(scl_in, 4))
		else $error("reference on outside a condition");
	conv_power_a: assert property (power_mode_out[0] |=> adc_power_out)
		else $error("converter off with power bit set");
	idle_power_a: assert property ((!core_clk_en_out && !power_mode_out[0]) [*2]
		|-> !adc_power_out)
		else $error("converter powered while idle");
	cmd_low_clock_a: assert property ($changed(power_mode_out) ||
		$changed(input_mode_select_out) |-> !scl_in)
		else $error("command applied with clock high");
	// Main scenarios reached
	cover property (conv_start_out);
	cover property ($rose(ref_on_out));
	cover property ($fell(sda_oe_out));
endmodule

bind adc_link_slave adc_link_slave_asserts u_chk (.mclk_in, .rstn_in, .scl_in, .conv_done_in,
	.sda_o_out, .sda_oe_out, .conv_start_out, .mux_pos_out, .mux_neg_out,
	.input_mode_select_out, .power_mode_out, .ref_on_out, .adc_power_out, .core_clk_en_out);

// ### dv/adc_link_slave_tb.sv
// Self-checking bench for the two-wire converter slave
module adc_link_slave_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_in, rstn_in, scl_w, m_sda, sda_w, conv_done, sda_o, sda_oe, conv_start;
	logic neg_shared, mode, ref_on, adc_pwr, clk_en, ref_m, pend_m;
	logic [1:0] sel, pd, pd_m;
	logic [6:0] mux_m;
	logic [2:0] mux_pos, mux_neg;
	logic [9:0] result, last, code;
	logic [9:0] q[$];
	logic [4:0] dt;
	int seed, miscompares, n_checks, n_starts, exp_starts, busy;
	// --------------------------------------------------------------
	// Wiring: open-drain data line with pull-up
	// --------------------------------------------------------------
	assign sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
	two_wire_master u_m (.mclk_in(mclk_in), .sda_in(sda_w), .scl_out(scl_w), .sda_out(m_sda));
	adc_link_slave u_dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .scl_in(scl_w), .sda_in(sda_w),
		.addr_select_pin1_in(sel[1]), .addr_select_pin0_in(sel[0]),
		.conv_done_in(conv_done), .result_in(result), .sda_o_out(sda_o), .sda_oe_out(sda_oe),
		.conv_start_out(conv_start), .mux_pos_out(mux_pos), .mux_neg_out(mux_neg),
		.neg_common_out(neg_shared), .input_mode_select_out(mode), .power_mode_out(pd),
		.ref_on_out(ref_on), .adc_power_out(adc_pwr), .core_clk_en_out(clk_en));
	initial begin
		mclk_in = 1'b0;
		forever #10 mclk_in = ~mclk_in;
	end
	// Converter core: random code ten cycles after each start
	always @(negedge mclk_in) begin
		conv_done <= 1'b0;
		if (conv_start) begin
			n_starts++;
			busy = 10;
		end else if (busy > 0) begin
			busy--;
			if (busy == 0) begin
				code = 10'($random(seed));
				result <= code;
				conv_done <= 1'b1;
				q.push_back(code);
			end
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask
	task automatic stop_test();
		if (miscompares == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Pending reference takes effect at stop or start
	task automatic take_ref();
		if (pend_m)
			ref_m = 1'b1;
		pend_m = 1'b0;
	endtask
	task automatic addr(input logic [7:0] a, input logic hit);
		logic [7:0] rx;
		logic ak;
		u_m.start_c();
		take_ref();
		u_m.xfer(a, 1'b1, rx, ak);
		chk("addr ack", ak, !hit);
		chk("ref", ref_on, ref_m);
	endtask
	task automatic send_cmd(input logic [7:0] c);
		logic [7:0] rx;
		logic ak;
		// A full buffer refuses the start and keeps the old channel
		if (q.size() < 32) begin
			exp_starts++;
			mux_m = {c[5:4], c[6], c[5:4], ~c[6], c[7]};
		end
		pd_m = c[3:2];
		if (!c[3])
			{ref_m, pend_m} = 2'h0;
		else if (!ref_m)
			pend_m = 1'b1;
		u_m.xfer(c, 1'b1, rx, ak);
		chk("cmd ack", ak, 0);
		chk("mode", mode, c[7]);
		chk("power", pd, pd_m);
		chk("pos", mux_pos, mux_m[6:4]);
		chk("neg", mux_neg, mux_m[3:1]);
		chk("common", neg_shared, mux_m[0]);
		chk("ref", ref_on, ref_m);
	endtask
	// Master acks every byte but the last; empty buffer repeats the code
	task automatic rd_pairs(input int n);
		logic [7:0] rx;
		logic ak;
		for (int i = 0; i < 2 * n; i++) begin
			if (i % 2 == 0 && q.size() > 0)
				last = q.pop_front();
			u_m.xfer(8'hff, i == 2 * n - 1, rx, ak);
			if (i % 2)
				chk("low byte", rx, {last[5:0], 2'h0});
			else
				chk("high byte", rx, {4'h0, last[9:6]});
		end
	endtask
	task automatic end_xfer();
		u_m.stop_c();
		take_ref();
		repeat (20) @(negedge mclk_in);
		chk("released", sda_oe, 0);
		chk("ref", ref_on, ref_m);
		chk("core clk", clk_en, 0);
		chk("adc power", adc_pwr, pd_m[0]);
		chk("starts", n_starts, exp_starts);
	endtask
	// Hang guard, well past the expected run
	initial begin
		#1_000_000;
		miscompares++;
		stop_test();
	end
	initial begin
		seed = 18;
		sel = 2'($random(seed));
		dt = adc_link_pkg::DEV_TYPE;
		{rstn_in, last, ref_m, pend_m, mux_m, pd_m} = '0;
		repeat (2) @(negedge mclk_in);
		rstn_in = 1'b1;
		repeat (6) @(negedge mclk_in);
		chk("reset", {sda_oe, conv_start, ref_on, adc_pwr, clk_en, pd, mux_pos, mode}, 0);
		addr({dt ^ 5'h01, sel, 1'b0}, 1'b0);
		end_xfer();
		addr({dt, ~sel[1], sel[0], 1'b1}, 1'b0);
		end_xfer();
		addr({dt, sel[1], ~sel[0], 1'b0}, 1'b0);
		end_xfer();
		// Every mode, channel and power code
		for (int i = 0; i < 16; i++) begin
			addr({dt, sel, 1'b0}, 1'b1);
			send_cmd({4'(i), 2'(i) ^ 2'(i >> 2), 2'($random(seed))});
			end_xfer();
		end
		// Long write fills the buffer until starts are refused
		addr({dt, sel, 1'b0}, 1'b1);
		repeat (17) send_cmd(8'h5c ^ 8'($random(seed)) & 8'hf3);
		end_xfer();
		addr({dt, sel, 1'b1}, 1'b1);
		rd_pairs(33);
		end_xfer();
		// Reference turns on at a repeated start, read follows directly
		addr({dt, sel, 1'b0}, 1'b1);
		send_cmd(8'h84);
		send_cmd(8'h98);
		addr({dt, sel, 1'b1}, 1'b1);
		rd_pairs(2);
		end_xfer();
		stop_test();
	end
endmodule
